// ==== src/ircr_pkg.sv ====
// Shared constants and types for the charger interrupt and status registers.
`default_nettype none

package ircr_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int SYNC_TIME_NS  = 200;
   localparam int SYNC_CYCLES   =
      (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] SYNC_CNT_LOAD = 4'(SYNC_CYCLES);
   localparam logic [3:0] SYNC_CNT_LAST = 4'h1;

   // ***************************************************************
   // Serial port
   // ***************************************************************
   // Arbitrary default bus address; the real part fixes its own.
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
   localparam logic [3:0] BYTE_BITS        = 4'h8;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [7:0] ADDR_MONITOR_CONTROL = 8'h09;
   localparam logic [7:0] ADDR_IRQ_ENABLE      = 8'h0a;
   localparam logic [7:0] ADDR_CONFIG_CONTROL  = 8'h0b;
   localparam logic [7:0] ADDR_IRQ_FLAGS       = 8'h0c;
   localparam logic [7:0] ADDR_CHARGER_STATUS  = 8'h0d;
   localparam logic [7:0] ADDR_MON_DATA_LOW    = 8'h0e;
   localparam logic [7:0] ADDR_MON_DATA_MID    = 8'h0f;
   localparam logic [7:0] ADDR_MON_DATA_HIGH   = 8'h10;
   localparam logic [7:0] ADDR_TEMP_RESULT     = 8'h11;

   // ***************************************************************
   // Fields and reset values
   // ***************************************************************
   localparam int MON_EN_BIT      = 0;
   localparam int CTRL_UPDATE_BIT = 0;
   localparam int CTRL_SYNC_BIT   = 2;
   localparam int FLAG_SERIAL_RDY = 0;
   localparam int FLAG_UNDER_DIS  = 1;
   localparam int FLAG_OVER_CH    = 2;
   localparam int FLAG_SRC_LOW    = 3;
   localparam int FLAG_TEMP       = 4;
   localparam int FLAG_MON_DONE   = 5;
   localparam int FLAG_MON_ERR    = 6;
   localparam int NUM_FLAGS       = 7;

   localparam logic [7:0] MON_CTRL_RESET = 8'h00;
   localparam logic [7:0] MON_CTRL_MASK  = 8'h0f;
   localparam logic [6:0] IRQ_EN_RESET   = 7'h01;
   localparam logic [6:0] IRQ_FLAG_RESET = 7'h01;
   localparam logic [6:0] IRQ_FLAG_ALL   = 7'h7f;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef struct packed {
      logic charge_disable_pin;
      logic boost_idle;
      logic temp_outside;
      logic source_low;
      logic over_charge;
      logic under_discharge;
   } ircr_levels_t;

   typedef struct packed {
      logic [3:0]  shift;
      logic [19:0] data;
   } ircr_monitor_t;

   typedef enum logic [6:0] {
      ST_IDLE     = 7'h01,
      ST_ADDR     = 7'h02,
      ST_ADDR_ACK = 7'h04,
      ST_WR_BYTE  = 7'h08,
      ST_WR_ACK   = 7'h10,
      ST_RD_BYTE  = 7'h20,
      ST_RD_ACK   = 7'h40
   } ircr_i2c_state_t;

   typedef struct packed {
      ircr_i2c_state_t i2c_st;
      logic            scl_q;
      logic            sda_q;
      logic [3:0]      bit_cnt;
      logic [7:0]      shift;
      logic [7:0]      tx;
      logic            rw;
      logic            ptr_pending;
      logic [7:0]      ptr;
      logic            sda_drive;
      ircr_levels_t    levels_q;
      logic            ready_q;
      logic [7:0]      mon_ctrl;
      logic [6:0]      irq_en;
      logic [6:0]      act_irq_en;
      logic            act_mon_en;
      logic            cfg_source;
      logic            sync_busy;
      logic [3:0]      sync_cnt;
      logic [6:0]      irq_flags;
      ircr_monitor_t   monitor;
      logic [7:0]      temp;
      logic            irq;
      logic            inhibit;
   } ircr_state_t;

endpackage

`default_nettype wire

// ==== src/ircr_pin_sync.sv ====
// Three-stage input synchroniser with agreement filter, one lane per bit.
`default_nettype none

module ircr_pin_sync
   import ircr_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Pins
   input  wire logic [W-1:0] pins_async,
   output logic      [W-1:0] pins
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] filt;
   } ircr_sync_state_t;

   ircr_sync_state_t s_reg;
   ircr_sync_state_t s_next;
   logic [W-1:0]     filt_next;

   // A lane follows the pin only once stages two and three agree.
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_lane
         assign filt_next[i] = (s_reg.s2[i] == s_reg.s3[i]) ?
                               s_reg.s3[i] : s_reg.filt[i];
      end
   endgenerate

   always_comb begin
      s_next      = s_reg;
      s_next.s1   = pins_async;
      s_next.s2   = s_reg.s1;
      s_next.s3   = s_reg.s2;
      s_next.filt = filt_next;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pins = s_reg.filt;

endmodule

`default_nettype wire

// ==== src/ircr_regs.sv ====
// Interrupt, status, configuration and monitor registers behind a serial port.
//
// Operation
// - Monitor runs only while enable bit set
// - Per-event enables gate the interrupt pin
// - Ready enable resets set; ready raises flag
// - Flags mirror enables; reading clears them
// - Temperature threshold crossing sets temperature flag
// - Source target crossing low level sets flag
// - Battery crossing charge limits sets flags
// - Monitor result and error set flags
// - Control bit zero selects configuration source
// - Settings apply only after update write
// - Busy bit reads set; writes refused meanwhile
// - Back to pins keeps enables and flags
// - Status bit seven shows charge-disable pin
// - Status bit six shows boost idle
// - Status bit four shows temperature outside window
// - Status bit three shows source target low
// - Status bits two, one show battery limits
// - Twenty-bit monitor result with shift field
// - Temperature result register holds ADC value
// - Charging inhibited by register bit or pin
`default_nettype none

module ircr_regs
   import ircr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Serial port, open drain data line
   input  wire logic          scl_in,
   input  wire logic          sda_in,
   output logic               sda_out,
   output logic               sda_oe,
   // Analog comparator levels, asynchronous
   input  wire logic          charge_disable_pin,
   input  wire logic          boost_idle_in,
   input  wire logic          temp_outside_in,
   input  wire logic          source_low_in,
   input  wire logic          over_charge_in,
   input  wire logic          under_discharge_in,
   // On-chip events and results, same clock
   input  wire logic          cold_start_done,
   input  wire logic          monitor_done,
   input  wire logic          monitor_error,
   input  wire ircr_monitor_t monitor_result,
   input  wire logic [7:0]    temp_result,
   input  wire logic          charge_disable_bit,
   // Outputs to the charger
   output logic               irq,
   output logic               monitor_enable,
   output logic               config_from_serial,
   output logic               sync_in_progress,
   output logic               charging_inhibit
);

   // ***************************************************************
   // Input synchronisation
   // ***************************************************************
   localparam int NUM_SYNC = 8;

   logic [NUM_SYNC-1:0] raw_pins;
   logic [NUM_SYNC-1:0] syn_pins;
   ircr_levels_t        lev;
   logic                scl;
   logic                sda;

   // Bus lanes pass inverted so a cleared stage reads as an idle bus.
   assign raw_pins = {~scl_in, ~sda_in, charge_disable_pin, boost_idle_in,
                      temp_outside_in, source_low_in, over_charge_in,
                      under_discharge_in};

   ircr_pin_sync #(
      .W          (NUM_SYNC)
   ) u_sync (
      .clk        (clk),
      .rst        (rst),
      .pins_async (raw_pins),
      .pins       (syn_pins)
   );

   assign scl = ~syn_pins[7];
   assign sda = ~syn_pins[6];
   assign lev = ircr_levels_t'(syn_pins[5:0]);

   // ***************************************************************
   // State
   // ***************************************************************
   localparam ircr_state_t STATE_RESET = '{
      i2c_st:      ST_IDLE,
      scl_q:       1'b1,
      sda_q:       1'b1,
      bit_cnt:     4'h0,
      shift:       8'h00,
      tx:          8'h00,
      rw:          1'b0,
      ptr_pending: 1'b1,
      ptr:         8'h00,
      sda_drive:   1'b0,
      levels_q:    '0,
      ready_q:     1'b0,
      mon_ctrl:    MON_CTRL_RESET,
      irq_en:      IRQ_EN_RESET,
      act_irq_en:  IRQ_EN_RESET,
      act_mon_en:  1'b0,
      cfg_source:  1'b0,
      sync_busy:   1'b0,
      sync_cnt:    4'h0,
      irq_flags:   IRQ_FLAG_RESET,
      monitor:     '0,
      temp:        8'h00,
      irq:         1'b0,
      inhibit:     1'b0
   };

   ircr_state_t s_reg;
   ircr_state_t s_next;

   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;
   logic [7:0]  rd_byte;
   logic [6:0]  events;

   assign scl_rise   = scl & ~s_reg.scl_q;
   assign scl_fall   = ~scl & s_reg.scl_q;
   assign start_cond = scl & s_reg.scl_q & s_reg.sda_q & ~sda;
   assign stop_cond  = scl & s_reg.scl_q & ~s_reg.sda_q & sda;

   // ***************************************************************
   // Read multiplexer
   // ***************************************************************
   function automatic logic [7:0] read_reg(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         ADDR_MONITOR_CONTROL: v = s_reg.mon_ctrl;
         ADDR_IRQ_ENABLE:      v = {1'b0, s_reg.irq_en};
         ADDR_CONFIG_CONTROL: begin
            v[CTRL_SYNC_BIT]   = s_reg.sync_busy;
            v[CTRL_UPDATE_BIT] = s_reg.cfg_source;
         end
         ADDR_IRQ_FLAGS:       v = {1'b0, s_reg.irq_flags};
         ADDR_CHARGER_STATUS: begin
            v[7] = lev.charge_disable_pin;
            v[6] = lev.boost_idle;
            v[4] = lev.temp_outside;
            v[3] = lev.source_low;
            v[2] = lev.over_charge;
            v[1] = lev.under_discharge;
         end
         ADDR_MON_DATA_LOW:    v = s_reg.monitor.data[7:0];
         ADDR_MON_DATA_MID:    v = s_reg.monitor.data[15:8];
         ADDR_MON_DATA_HIGH:
            v = {s_reg.monitor.shift, s_reg.monitor.data[19:16]};
         ADDR_TEMP_RESULT:     v = s_reg.temp;
         default:              v = 8'h00;
      endcase
      return v;
   endfunction

   always_comb rd_byte = read_reg(s_reg.ptr);

   // ***************************************************************
   // Event detection
   // ***************************************************************
   // Comparator flags fire on any change of level, so both directions
   // of a crossing are reported.
   always_comb begin
      events                  = 7'h00;
      events[FLAG_SERIAL_RDY] = cold_start_done & ~s_reg.ready_q;
      events[FLAG_UNDER_DIS]  = lev.under_discharge ^
                                s_reg.levels_q.under_discharge;
      events[FLAG_OVER_CH]    = lev.over_charge ^
                                s_reg.levels_q.over_charge;
      events[FLAG_SRC_LOW]    = lev.source_low ^
                                s_reg.levels_q.source_low;
      events[FLAG_TEMP]       = lev.temp_outside ^
                                s_reg.levels_q.temp_outside;
      events[FLAG_MON_DONE]   = monitor_done;
      events[FLAG_MON_ERR]    = monitor_error;
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      logic       rd_clr;
      logic       wr_en;
      logic [7:0] wr_addr;
      logic [7:0] wr_data;
      rd_clr  = 1'b0;
      wr_en   = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
      s_next  = s_reg;

      s_next.scl_q    = scl;
      s_next.sda_q    = sda;
      s_next.levels_q = lev;
      s_next.ready_q  = cold_start_done;

      // Serial port engine. Data is sampled on the clock rise and the
      // data line only changes after the clock fall.
      if (start_cond) begin
         s_next.i2c_st      = ST_ADDR;
         s_next.bit_cnt     = 4'h0;
         s_next.sda_drive   = 1'b0;
         s_next.ptr_pending = 1'b1;
      end else if (stop_cond) begin
         s_next.i2c_st    = ST_IDLE;
         s_next.sda_drive = 1'b0;
      end else begin
         unique case (s_reg.i2c_st)
            ST_IDLE: begin
               s_next.sda_drive = 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  s_next.shift   = {s_reg.shift[6:0], sda};
                  s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
               end else if (scl_fall && s_reg.bit_cnt == BYTE_BITS) begin
                  if (s_reg.shift[7:1] == DEV_ADDR) begin
                     s_next.i2c_st    = ST_ADDR_ACK;
                     s_next.sda_drive = 1'b1;
                     s_next.rw        = s_reg.shift[0];
                  end else begin
                     s_next.i2c_st = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK, ST_RD_ACK: begin
               if (s_reg.i2c_st == ST_RD_ACK && scl_rise && sda) begin
                  s_next.i2c_st = ST_IDLE;
               end else if (scl_fall) begin
                  if (s_reg.i2c_st == ST_RD_ACK || s_reg.rw) begin
                     s_next.i2c_st    = ST_RD_BYTE;
                     s_next.tx        = rd_byte;
                     s_next.sda_drive = ~rd_byte[7];
                     s_next.ptr       = s_reg.ptr + 8'h01;
                     s_next.bit_cnt   = 4'h0;
                     rd_clr = (s_reg.ptr == ADDR_IRQ_FLAGS);
                  end else begin
                     s_next.i2c_st    = ST_WR_BYTE;
                     s_next.sda_drive = 1'b0;
                     s_next.bit_cnt   = 4'h0;
                  end
               end
            end
            ST_WR_BYTE: begin
               if (scl_rise) begin
                  s_next.shift   = {s_reg.shift[6:0], sda};
                  s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
               end else if (scl_fall && s_reg.bit_cnt == BYTE_BITS) begin
                  s_next.i2c_st    = ST_WR_ACK;
                  s_next.sda_drive = 1'b1;
                  if (s_reg.ptr_pending) begin
                     s_next.ptr         = s_reg.shift;
                     s_next.ptr_pending = 1'b0;
                  end else begin
                     wr_en      = 1'b1;
                     wr_addr    = s_reg.ptr;
                     wr_data    = s_reg.shift;
                     s_next.ptr = s_reg.ptr + 8'h01;
                  end
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  s_next.i2c_st    = ST_WR_BYTE;
                  s_next.sda_drive = 1'b0;
                  s_next.bit_cnt   = 4'h0;
               end
            end
            ST_RD_BYTE: begin
               if (scl_rise) begin
                  s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (s_reg.bit_cnt == BYTE_BITS) begin
                     s_next.i2c_st    = ST_RD_ACK;
                     s_next.sda_drive = 1'b0;
                  end else begin
                     s_next.tx        = {s_reg.tx[6:0], 1'b0};
                     s_next.sda_drive = ~s_reg.tx[6];
                  end
               end
            end
            default: begin
               s_next.i2c_st    = ST_IDLE;
               s_next.sda_drive = 1'b0;
            end
         endcase
      end

      // Monitor and enable writes land in the shadow copies only; the charger
      // sees them after the next update that selects the serial source, and its sync.
      if (wr_en && !s_reg.sync_busy) begin
         unique case (wr_addr)
            ADDR_MONITOR_CONTROL: begin
               s_next.mon_ctrl = wr_data & MON_CTRL_MASK;
            end
            ADDR_IRQ_ENABLE: begin
               s_next.irq_en = wr_data[6:0];
            end
            ADDR_CONFIG_CONTROL: begin
               s_next.cfg_source = wr_data[CTRL_UPDATE_BIT];
               s_next.sync_busy  = 1'b1;
               s_next.sync_cnt   = SYNC_CNT_LOAD;
            end
            default: begin
            end
         endcase
      end else if (s_reg.sync_busy) begin
         s_next.sync_cnt = s_reg.sync_cnt - 4'h1;
         if (s_reg.sync_cnt == SYNC_CNT_LAST) begin
            s_next.sync_busy = 1'b0;
            if (s_reg.cfg_source) begin
               s_next.act_irq_en = s_reg.irq_en;
               s_next.act_mon_en = s_reg.mon_ctrl[MON_EN_BIT];
            end else begin
               // Pin configuration has no monitor setting, so the
               // monitor stops; enables and flags are left alone.
               s_next.act_mon_en = 1'b0;
            end
         end
      end

      // A flag set in the same cycle as the clearing read survives.
      s_next.irq_flags = (s_reg.irq_flags &
                          ~(rd_clr ? IRQ_FLAG_ALL : 7'h00)) | events;

      if (monitor_done) begin
         s_next.monitor = monitor_result;
      end
      s_next.temp    = temp_result;
      s_next.irq     = |(s_next.irq_flags & s_next.act_irq_en);
      s_next.inhibit = charge_disable_bit | lev.charge_disable_pin;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= STATE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign sda_out            = 1'b0;
   assign sda_oe             = s_reg.sda_drive;
   assign irq                = s_reg.irq;
   assign monitor_enable     = s_reg.act_mon_en;
   assign config_from_serial = s_reg.cfg_source;
   assign sync_in_progress   = s_reg.sync_busy;
   assign charging_inhibit   = s_reg.inhibit;

endmodule

`default_nettype wire

// ==== tb/ircr_regs_props.sv ====
// Timing checker for the interrupt and status register block.
`default_nettype none

module ircr_regs_props
   import ircr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Watched ports
   input wire logic charge_disable_pin,
   input wire logic charge_disable_bit,
   input wire logic irq,
   input wire logic monitor_enable,
   input wire logic config_from_serial,
   input wire logic sync_in_progress,
   input wire logic charging_inhibit
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************
   // Properties
   // ************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_inhibit_by_bit: assert property (
      charge_disable_bit |=> charging_inhibit)
      else $error("inhibit missed register bit");
   a_inhibit_by_pin: assert property (
      charge_disable_pin [*6] |=> charging_inhibit)
      else $error("inhibit missed pin");
   a_inhibit_clear: assert property (
      (!charge_disable_bit && !charge_disable_pin) [*6] |=> !charging_inhibit)
      else $error("inhibit without cause");
   a_ready_irq: assert property (
      $fell(rst) |-> ##[0:2] irq)
      else $error("no ready interrupt after reset");
   a_busy_length: assert property (
      $rose(sync_in_progress) |-> sync_in_progress [*8] ##1 !sync_in_progress)
      else $error("busy length wrong");
   a_apply_on_sync: assert property (
      $changed(monitor_enable)
         |-> $past(sync_in_progress) || $past(sync_in_progress, 2))
      else $error("monitor enable changed outside sync");
   a_pins_stop_mon: assert property (
      $fell(sync_in_progress) && !config_from_serial
         |-> ##[0:1] !monitor_enable)
      else $error("monitor still on under pin config");
   a_busy_steady: assert property (
      sync_in_progress && $past(sync_in_progress) |-> $stable(config_from_serial))
      else $error("config source moved while busy");
endmodule

bind ircr_regs ircr_regs_props u_props (.clk, .rst, .charge_disable_pin,
   .charge_disable_bit, .irq, .monitor_enable, .config_from_serial,
   .sync_in_progress, .charging_inhibit);

`default_nettype wire

// ==== tb/ircr_i2c_host.sv ====
// Serial host model that writes and reads the register bank.
`default_nettype none

module ircr_i2c_host
   import ircr_pkg::*;
#(
   parameter int H = 10
) (
   // Clock and bus
   input  wire logic       clk,
   input  wire logic       sda,
   output logic            scl,
   output logic            oe,
   // Read results
   output logic [7:0]      rd_data,
   output logic            rd_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************
   // Bus cycles
   // ************
   initial begin
      scl = 1'b1;
      oe = 1'b0;
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end
   task automatic q(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Data moves two cycles after the clock falls, so the filtered pins
   // never see it change while the clock is still high.
   task automatic bt(input logic b, output logic r);
      q(2);
      oe <= ~b;
      q(H);
      scl <= 1'b1;
      q(5);
      r = sda;
      q(5);
      scl <= 1'b0;
   endtask
   task automatic start;
      q(2);
      oe <= 1'b0;
      q(H);
      scl <= 1'b1;
      q(H);
      oe <= 1'b1;
      q(H);
      scl <= 1'b0;
   endtask
   task automatic stop;
      q(2);
      oe <= 1'b1;
      q(H);
      scl <= 1'b1;
      q(H);
      oe <= 1'b0;
      q(H);
   endtask
   task automatic put8(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bt(d[i], r);
      bt(1'b1, r);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start;
      put8({DEV_ADDR_DEFAULT, 1'b0});
      put8(a);
      put8(d);
      stop;
   endtask
   task automatic rd(input logic [7:0] a);
      logic [7:0] d;
      logic       r;
      start;
      put8({DEV_ADDR_DEFAULT, 1'b0});
      put8(a);
      start;
      put8({DEV_ADDR_DEFAULT, 1'b1});
      for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
      bt(1'b1, r);
      rd_data <= d;
      rd_valid <= 1'b1;
      q(1);
      rd_valid <= 1'b0;
      stop;
   endtask
endmodule

`default_nettype wire

// ==== tb/ircr_regs_tb.sv ====
// Self-checking bench for the interrupt and status register block.
`default_nettype none

module ircr_regs_tb;
   import ircr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk, rst, charge_disable_pin, boost_idle_in, temp_outside_in;
   logic source_low_in, over_charge_in, under_discharge_in;
   logic cold_start_done, monitor_done, monitor_error, charge_disable_bit;
   logic sda_out, sda_oe, irq, monitor_enable, config_from_serial;
   logic sync_in_progress, charging_inhibit, scl, hoe, rv;
   ircr_monitor_t monitor_result;
   logic [7:0] temp_result, rdat, expf;
   logic [6:0] lv;
   logic [7:0] expq[$];
   int mismatches, checked, cyc;
   int seed = 99741;
   // The data line idles high through its pull-up.
   wire sda = !(hoe | (sda_oe & !sda_out));

   ircr_regs dut (.clk, .rst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
      .charge_disable_pin, .boost_idle_in, .temp_outside_in, .source_low_in,
      .over_charge_in, .under_discharge_in, .cold_start_done, .monitor_done,
      .monitor_error, .monitor_result, .temp_result, .charge_disable_bit,
      .irq, .monitor_enable, .config_from_serial, .sync_in_progress,
      .charging_inhibit);
   ircr_i2c_host host (.clk, .sda, .scl, .oe(hoe), .rd_data(rdat),
      .rd_valid(rv));

   // ************
   // Checking
   // ************
   task automatic chk(input logic [7:0] s, input logic [7:0] e,
                      input string n);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      host.rd(a);
   endtask
   always @(posedge clk) if (rv === 1'b1) chk(rdat, expq.pop_front(), "rd");
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         results();
      end
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ************
   // Scenarios
   // ************
   initial begin
      {charge_disable_bit, charge_disable_pin, boost_idle_in} = '0;
      {temp_outside_in, source_low_in, over_charge_in} = '0;
      {under_discharge_in, cold_start_done, monitor_done} = '0;
      {monitor_error, monitor_result, temp_result} = '0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rdx(ADDR_IRQ_ENABLE, 8'h01);
      rdx(ADDR_IRQ_FLAGS, 8'h01);
      rdx(ADDR_IRQ_FLAGS, 8'h00);
      chk({7'h0, irq}, 8'h00, "irq");
      host.wr(ADDR_MONITOR_CONTROL, 8'h03);
      host.wr(ADDR_IRQ_ENABLE, 8'h7f);
      chk({6'h0, config_from_serial, monitor_enable}, 8'h00, "cfg");
      rdx(ADDR_MONITOR_CONTROL, 8'h03);
      rdx(ADDR_IRQ_ENABLE, 8'h7f);
      host.wr(ADDR_CONFIG_CONTROL, 8'h01);
      chk({6'h0, config_from_serial, monitor_enable}, 8'h03, "cfg");
      rdx(ADDR_CONFIG_CONTROL, 8'h01);
      lv = 7'($random(seed));
      monitor_result <= 24'($random(seed));
      temp_result <= 8'($random(seed));
      {charge_disable_bit, charge_disable_pin, boost_idle_in,
       temp_outside_in, source_low_in, over_charge_in,
       under_discharge_in} <= lv;
      monitor_done <= 1'b1;
      monitor_error <= 1'b1;
      @(posedge clk);
      monitor_done <= 1'b0;
      monitor_error <= 1'b0;
      repeat (10) @(posedge clk);
      chk({7'h0, irq}, 8'h01, "irq");
      chk({7'h0, charging_inhibit}, {7'h0, lv[6] | lv[5]}, "inhibit");
      expf = {3'b011, lv[3:0], 1'b0};
      rdx(ADDR_CHARGER_STATUS, {lv[5:4], 1'b0, lv[3:0], 1'b0});
      rdx(ADDR_MON_DATA_LOW, monitor_result.data[7:0]);
      rdx(ADDR_MON_DATA_MID, monitor_result.data[15:8]);
      rdx(ADDR_MON_DATA_HIGH,
          {monitor_result.shift, monitor_result.data[19:16]});
      host.wr(ADDR_TEMP_RESULT, ~temp_result);
      rdx(ADDR_TEMP_RESULT, temp_result);
      rdx(ADDR_IRQ_FLAGS, expf);
      chk({7'h0, irq}, 8'h00, "irq");
      cold_start_done <= 1'b1;
      host.wr(ADDR_CONFIG_CONTROL, 8'h00);
      chk({6'h0, config_from_serial, monitor_enable}, 8'h00, "cfg");
      chk({7'h0, irq}, 8'h01, "irq");
      rdx(ADDR_IRQ_ENABLE, 8'h7f);
      rdx(ADDR_IRQ_FLAGS, 8'h01);
      chk({7'h0, irq}, 8'h00, "irq");
      monitor_error <= 1'b1;
      @(posedge clk);
      monitor_error <= 1'b0;
      repeat (3) @(posedge clk);
      chk({7'h0, irq}, 8'h01, "irq");
      charge_disable_bit <= 1'b0;
      charge_disable_pin <= 1'b1;
      repeat (8) @(posedge clk);
      chk({7'h0, charging_inhibit}, 8'h01, "inhibit");
      charge_disable_bit <= 1'b1;
      charge_disable_pin <= 1'b0;
      repeat (8) @(posedge clk);
      chk({7'h0, charging_inhibit}, 8'h01, "inhibit");
      charge_disable_bit <= 1'b0;
      repeat (8) @(posedge clk);
      chk({7'h0, charging_inhibit}, 8'h00, "inhibit");
      rdx(8'h20, 8'h00);
      repeat (20) @(posedge clk);
      results();
   end
endmodule

`default_nettype wire
